// ==== clk_trig_defs.vh ====
// constants for the clock and trigger recovery block
`ifndef CLK_TRIG_DEFS_VH
`define CLK_TRIG_DEFS_VH

// ----------------------------------------
// timing, in picoseconds and in clocks
// ----------------------------------------
`define CLK_PERIOD_PS    32'd4000
`define REF_PERIOD_PS    32'd24950
`define REF_CYCLES       (`REF_PERIOD_PS / `CLK_PERIOD_PS)
`define REF_CYCLES_6     6'd6
`define PER_BELOW        6'd1
`define PER_ABOVE        6'd2
`define MIN_GAP          6'd3
`define FLY_SLACK        6'd1
`define LOCK_EDGES       4'hf

// ----------------------------------------
// register selector codes
// ----------------------------------------
`define SEL_CTRL_ONE     2'h0
`define SEL_CTRL_TWO     2'h1
`define SEL_DAC_LOW      2'h2
`define SEL_SHARED       2'h3

// ----------------------------------------
// field positions and phase step limit
// ----------------------------------------
`define C1_MODE          7
`define C1_DIS_TRIG      6
`define C1_TSEL_HI       5
`define C1_TSEL_LO       4
`define C1_RESTART       3
`define C1_FORCE_PFD     2
`define C1_HIGH_GAIN     1
`define C1_GOING         0
`define C2_GOING_FORCE   7
`define C2_GAIN_FORCE    6
`define C2_SHARED_SEL    5
`define C2_HALF          4
`define PHASE_STEP_MAX   4'hb

// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_BYTE         8'h00
`define RST_FLAG         1'b0
`define RST_BIAS         16'h0000
`endif

// ==== seu_vote_reg.v ====
// triplicated register with majority vote and disagreement flag
module seu_vote_reg #(
    parameter              WIDTH     = 8,
    parameter [WIDTH-1:0]  RESET_VAL = {WIDTH{1'b0}}
) (
    // clock and control
    input  wire             clk,
    input  wire             rst,
    input  wire             ce,
    // write side
    input  wire             we,
    input  wire [WIDTH-1:0] d,
    // voted value and disagreement flag
    output wire [WIDTH-1:0] q,
    output wire             mismatch
);
    reg [WIDTH-1:0] copy_a;
    reg [WIDTH-1:0] copy_b;
    reg [WIDTH-1:0] copy_c;

    // copies are never scrubbed: a bad copy stays bad until rewritten
    always @(posedge clk)
    begin
        if (rst)
        begin
            copy_a <= RESET_VAL;
            copy_b <= RESET_VAL;
            copy_c <= RESET_VAL;
        end
        else if (ce && we)
        begin
            copy_a <= d;
            copy_b <= d;
            copy_c <= d;
        end
    end

    assign q        = (copy_a & copy_b) | (copy_a & copy_c) | (copy_b & copy_c);
    assign mismatch = |((copy_a ^ copy_b) | (copy_a ^ copy_c));
endmodule

// ==== clock_trigger_recovery_regs.v ====
// clock and trigger recovery from the encoded line, with byte-wide i2c register slave
`include "clk_trig_defs.vh"

module clock_trigger_recovery_regs #(
    parameter       CAL_DWELL = 12'd1024,
    // nominal line period in whole clocks; lock window and flywheel follow it
    parameter [5:0] REF_CLKS  = `REF_CYCLES_6
) (
    // clock, reset, enable
    input  wire        CLK_IN,
    input  wire        RST_IN,
    input  wire        CE_IN,
    // encoded clock and trigger line
    input  wire        ENC_LINE_IN,
    // i2c pins and address straps
    input  wire        SCL_IN,
    input  wire        SDA_IN,
    input  wire [4:0]  CHIP_ADDR_IN,
    output reg         SDA_OUT,
    output reg         SDA_OE_OUT,
    // recovered clock, trigger and phase control
    output reg         REF_CLK_OUT,
    output reg         TRIGGER_OUT,
    output reg         PHASE_HALF_OUT,
    output reg  [3:0]  PHASE_STEP_OUT,
    // loop bias and status
    output reg  [15:0] BIAS_OUT,
    output reg         HIGH_GAIN_OUT,
    output reg         GOING_OUT
);

    localparam ST_IDLE = 3'h0;
    localparam ST_ADDR = 3'h1;
    localparam ST_AACK = 3'h2;
    localparam ST_WR   = 3'h3;
    localparam ST_WACK = 3'h4;
    localparam ST_RD   = 3'h5;
    localparam ST_RACK = 3'h6;

    localparam CAL_IDLE  = 2'h0;
    localparam CAL_SWEEP = 2'h1;
    localparam CAL_DONE  = 2'h2;

    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    reg [2:0] line_sync;
    reg [2:0] scl_sync;
    reg [2:0] sda_sync;
    reg [4:0] strap_s1;
    reg [4:0] strap_s2;

    always @(posedge CLK_IN)
    begin
        if (RST_IN)
        begin
            line_sync <= 3'h0;
            scl_sync  <= 3'h7;
            sda_sync  <= 3'h7;
            strap_s1  <= 5'h00;
            strap_s2  <= 5'h00;
        end
        else if (CE_IN)
        begin
            line_sync <= {line_sync[1:0], ENC_LINE_IN};
            scl_sync  <= {scl_sync[1:0], SCL_IN};
            sda_sync  <= {sda_sync[1:0], SDA_IN};
            strap_s1  <= CHIP_ADDR_IN;
            strap_s2  <= strap_s1;
        end
    end

    wire line    = line_sync[1];
    wire line_up = line_sync[1] & ~line_sync[2];
    wire scl_up  = scl_sync[1] & ~scl_sync[2];
    wire scl_dn  = ~scl_sync[1] & scl_sync[2];
    wire i2c_go  = scl_sync[1] & scl_sync[2] & sda_sync[2] & ~sda_sync[1];
    wire i2c_end = scl_sync[1] & scl_sync[2] & ~sda_sync[2] & sda_sync[1];

    // ----------------------------------------
    // voted registers
    // ----------------------------------------
    reg        wr_strobe;
    reg [1:0]  wr_sel;
    reg [7:0]  wr_byte;
    wire [7:0] ctrl_one;
    wire [7:0] ctrl_two;
    wire [7:0] dac_low;
    wire [7:0] dac_high;
    wire [7:0] trig_delay;
    wire [4:0] mism;
    wire [4:0] reg_we;
    wire [39:0] reg_q;

    // selector 3 is steered by the shared-select bit of control two
    assign reg_we[0] = wr_strobe && wr_sel == `SEL_CTRL_ONE;
    assign reg_we[1] = wr_strobe && wr_sel == `SEL_CTRL_TWO;
    assign reg_we[2] = wr_strobe && wr_sel == `SEL_DAC_LOW;
    assign reg_we[3] = wr_strobe && wr_sel == `SEL_SHARED && !ctrl_two[`C2_SHARED_SEL];
    assign reg_we[4] = wr_strobe && wr_sel == `SEL_SHARED && ctrl_two[`C2_SHARED_SEL];

    genvar gi;
    generate
        for (gi = 0; gi < 5; gi = gi + 1)
        begin : g_regs
            seu_vote_reg #(
                .WIDTH     (8),
                .RESET_VAL (`RST_BYTE)
            ) u_reg (
                .clk      (CLK_IN),
                .rst      (RST_IN),
                .ce       (CE_IN),
                .we       (reg_we[gi]),
                .d        (wr_byte),
                .q        (reg_q[gi*8 +: 8]),
                .mismatch (mism[gi])
            );
        end
    endgenerate

    assign ctrl_one   = reg_q[7:0];
    assign ctrl_two   = reg_q[15:8];
    assign dac_low    = reg_q[23:16];
    assign dac_high   = reg_q[31:24];
    assign trig_delay = reg_q[39:32];

    // sticky upset flag; only a reset clears it, registers are not scrubbed
    reg seu_seen;
    always @(posedge CLK_IN)
    begin
        if (RST_IN)
            seu_seen <= `RST_FLAG;
        else if (CE_IN && |mism)
            seu_seen <= 1'b1;
    end

    // restart on a one-then-zero write sequence to the restart bit
    wire restart = reg_we[0] && ctrl_one[`C1_RESTART] && !wr_byte[`C1_RESTART];
    wire test_mode = ctrl_one[`C1_MODE];

    // ----------------------------------------
    // clock recovery and trigger decode
    // ----------------------------------------
    reg [5:0] per_cnt;
    reg [5:0] period;
    reg       seen_high;
    reg [3:0] lock_cnt;
    reg [14:0] trig_pipe;

    // a missing rise past the expected period ends the cycle on the flywheel
    wire fly_edge  = !line_up && per_cnt >= period + `FLY_SLACK;
    wire realign   = line_up && per_cnt < `MIN_GAP;
    wire boundary  = (line_up && !realign) || fly_edge;
    wire trig_now  = boundary && !seen_high;
    wire in_range  = per_cnt >= REF_CLKS - `PER_BELOW && per_cnt <= REF_CLKS + `PER_ABOVE;
    wire locked    = lock_cnt == `LOCK_EDGES;
    wire [15:0] dly_vec = {trig_pipe, trig_now};
    wire trig_tap  = dly_vec[trig_delay[3:0]];

    always @(posedge CLK_IN)
    begin
        if (RST_IN || (CE_IN && restart))
        begin
            per_cnt   <= 6'h00;
            period    <= REF_CLKS;
            // first boundary after a restart must not read as an accept
            seen_high <= 1'b1;
            lock_cnt  <= 4'h0;
            trig_pipe <= 15'h0000;
        end
        else if (CE_IN)
        begin
            if (boundary || realign)
                per_cnt <= 6'h00;
            else if (per_cnt != 6'h3f)
                per_cnt <= per_cnt + 6'h01;
            if (boundary)
                seen_high <= line;
            else if (line)
                seen_high <= 1'b1;
            if (line_up && !realign)
            begin
                if (in_range)
                begin
                    period <= per_cnt;
                    if (!locked)
                        lock_cnt <= lock_cnt + 4'h1;
                end
                else
                    lock_cnt <= 4'h0;
            end
            if (boundary)
                trig_pipe <= {trig_pipe[13:0], trig_now};
        end
    end

    // ----------------------------------------
    // auto calibration
    // ----------------------------------------
    reg [1:0]  cal_state;
    reg [15:0] cal_bias;
    reg [11:0] dwell;

    always @(posedge CLK_IN)
    begin
        if (RST_IN || (CE_IN && restart))
        begin
            cal_state <= CAL_IDLE;
            cal_bias  <= `RST_BIAS;
            dwell     <= 12'h000;
        end
        else if (CE_IN)
        begin
            case (cal_state)
                CAL_IDLE:
                begin
                    dwell     <= 12'h000;
                    cal_state <= CAL_SWEEP;
                end
                CAL_SWEEP:
                begin
                    if (locked)
                        cal_state <= CAL_DONE;
                    else if (dwell == CAL_DWELL - 12'h001)
                    begin
                        dwell    <= 12'h000;
                        cal_bias <= cal_bias + 16'h0001;
                    end
                    else
                        dwell <= dwell + 12'h001;
                end
                CAL_DONE:
                    cal_state <= CAL_DONE;
                default:
                    cal_state <= CAL_IDLE;
            endcase
        end
    end

    // test mode hands the bias, gain and going to the registers
    wire going_now = test_mode ? ctrl_two[`C2_GOING_FORCE] : cal_state == CAL_DONE;
    wire gain_now  = test_mode ? ctrl_two[`C2_GAIN_FORCE] : cal_state == CAL_SWEEP;

    // ----------------------------------------
    // i2c slave, one byte per transaction
    // ----------------------------------------
    reg [2:0] i2c_state;
    reg [3:0] bit_cnt;
    reg [7:0] shreg;
    reg [1:0] sel;
    reg       rd_req;
    reg [7:0] rd_byte;

    always @*
    begin
        case (sel)
            `SEL_CTRL_ONE: rd_byte = {ctrl_one[7:4], seu_seen, ctrl_one[`C1_FORCE_PFD],
                                      gain_now, going_now};
            `SEL_CTRL_TWO: rd_byte = ctrl_two;
            `SEL_DAC_LOW:  rd_byte = dac_low;
            default:       rd_byte = ctrl_two[`C2_SHARED_SEL] ? trig_delay : dac_high;
        endcase
    end

    always @(posedge CLK_IN)
    begin
        if (RST_IN)
        begin
            i2c_state  <= ST_IDLE;
            bit_cnt    <= 4'h0;
            shreg      <= 8'h00;
            sel        <= 2'h0;
            rd_req     <= 1'b0;
            wr_strobe  <= 1'b0;
            wr_sel     <= 2'h0;
            wr_byte    <= 8'h00;
            SDA_OUT    <= 1'b0;
            SDA_OE_OUT <= 1'b0;
        end
        else if (CE_IN)
        begin
            wr_strobe <= 1'b0;
            if (i2c_go)
            begin
                i2c_state  <= ST_ADDR;
                bit_cnt    <= 4'h0;
                SDA_OE_OUT <= 1'b0;
            end
            else if (i2c_end)
            begin
                i2c_state  <= ST_IDLE;
                SDA_OE_OUT <= 1'b0;
            end
            else
            begin
                case (i2c_state)
                    ST_ADDR, ST_WR:
                    begin
                        if (scl_up)
                        begin
                            shreg   <= {shreg[6:0], sda_sync[1]};
                            bit_cnt <= bit_cnt + 4'h1;
                        end
                        else if (scl_dn && bit_cnt == 4'h8)
                        begin
                            bit_cnt <= 4'h0;
                            if (i2c_state == ST_WR)
                            begin
                                wr_strobe  <= 1'b1;
                                wr_sel     <= sel;
                                wr_byte    <= shreg;
                                SDA_OE_OUT <= 1'b1;
                                i2c_state  <= ST_WACK;
                            end
                            else if (shreg[7:3] == strap_s2)
                            begin
                                sel        <= shreg[2:1];
                                rd_req     <= shreg[0];
                                SDA_OE_OUT <= 1'b1;
                                i2c_state  <= ST_AACK;
                            end
                            else
                                i2c_state <= ST_IDLE;
                        end
                    end
                    ST_AACK:
                    begin
                        if (scl_dn)
                        begin
                            if (rd_req)
                            begin
                                shreg      <= {rd_byte[6:0], 1'b0};
                                SDA_OE_OUT <= ~rd_byte[7];
                                bit_cnt    <= 4'h1;
                                i2c_state  <= ST_RD;
                            end
                            else
                            begin
                                SDA_OE_OUT <= 1'b0;
                                i2c_state  <= ST_WR;
                            end
                        end
                    end
                    ST_WACK:
                    begin
                        // further bytes are left unacknowledged
                        if (scl_dn)
                        begin
                            SDA_OE_OUT <= 1'b0;
                            i2c_state  <= ST_IDLE;
                        end
                    end
                    ST_RD:
                    begin
                        if (scl_dn)
                        begin
                            if (bit_cnt == 4'h8)
                            begin
                                SDA_OE_OUT <= 1'b0;
                                i2c_state  <= ST_RACK;
                            end
                            else
                            begin
                                SDA_OE_OUT <= ~shreg[7];
                                shreg      <= {shreg[6:0], 1'b0};
                                bit_cnt    <= bit_cnt + 4'h1;
                            end
                        end
                    end
                    ST_RACK:
                    begin
                        if (scl_up)
                            i2c_state <= ST_IDLE;
                    end
                    default:
                        i2c_state <= ST_IDLE;
                endcase
            end
        end
    end

    // ----------------------------------------
    // registered outputs
    // ----------------------------------------
    wire [3:0] step_req = ctrl_two[3:0];

    always @(posedge CLK_IN)
    begin
        if (RST_IN)
        begin
            REF_CLK_OUT    <= 1'b0;
            TRIGGER_OUT    <= 1'b0;
            PHASE_HALF_OUT <= 1'b0;
            PHASE_STEP_OUT <= 4'h0;
            BIAS_OUT       <= `RST_BIAS;
            HIGH_GAIN_OUT  <= 1'b0;
            GOING_OUT      <= 1'b0;
        end
        else if (CE_IN)
        begin
            // inversion supplies the second half period
            REF_CLK_OUT    <= (per_cnt < {1'b0, period[5:1]}) ^ ctrl_two[`C2_HALF];
            TRIGGER_OUT    <= boundary && trig_tap && !ctrl_one[`C1_DIS_TRIG]
                              && ctrl_one[`C1_TSEL_HI:`C1_TSEL_LO] == 2'h0;
            PHASE_HALF_OUT <= ctrl_two[`C2_HALF];
            // steps past the last first-half phase clamp to it
            PHASE_STEP_OUT <= step_req > `PHASE_STEP_MAX ? `PHASE_STEP_MAX : step_req;
            BIAS_OUT       <= test_mode ? {dac_high, dac_low} : cal_bias;
            HIGH_GAIN_OUT  <= gain_now;
            GOING_OUT      <= going_now;
        end
    end
endmodule

// ==== crr_checker_sva.sv ====
// assertion checker for the clock and trigger recovery block
module crr_checker (
    // clock and control
    input logic        CLK_IN,
    input logic        RST_IN,
    input logic        CE_IN,
    // link and i2c inputs
    input logic        ENC_LINE_IN,
    input logic        SCL_IN,
    input logic        SDA_IN,
    input logic [4:0]  CHIP_ADDR_IN,
    // outputs
    input logic        SDA_OUT,
    input logic        SDA_OE_OUT,
    input logic        REF_CLK_OUT,
    input logic        TRIGGER_OUT,
    input logic        PHASE_HALF_OUT,
    input logic [3:0]  PHASE_STEP_OUT,
    input logic [15:0] BIAS_OUT,
    input logic        HIGH_GAIN_OUT,
    input logic        GOING_OUT
);
    timeunit 1ns;
    timeprecision 1ps;
    // low longer than a full cycle means an accept; delay 15 still lands inside the lag
    localparam logic [9:0] LONG_LOW = 10'd32;
    localparam logic [9:0] MAX_LAG  = 10'd600;
    logic [9:0] low_run;
    logic [9:0] since_long;
    always @(posedge CLK_IN)
    begin
        if (RST_IN)
        begin
            low_run    <= 10'h000;
            since_long <= 10'h3ff;
        end
        else
        begin
            low_run    <= ENC_LINE_IN ? 10'h000 : low_run + 10'(low_run != 10'h3ff);
            since_long <= (low_run >= LONG_LOW) ? 10'h000 : since_long + 10'(since_long != 10'h3ff);
        end
    end
    default clocking cb @(posedge CLK_IN);
    endclocking
    default disable iff (RST_IN);
    sequence quiet_four;
        !TRIGGER_OUT [*4];
    endsequence
    sequence reset_left;
        $fell(RST_IN);
    endsequence
    a_trig_one_clock: assert property (TRIGGER_OUT |=> quiet_four)
        else $error("trigger pulse too long or too close");
    a_trig_after_low: assert property (TRIGGER_OUT |-> since_long < MAX_LAG)
        else $error("trigger without a low reference cycle");
    a_reset_clears: assert property (reset_left |-> !GOING_OUT && BIAS_OUT == 16'h0000)
        else $error("outputs not cleared by reset");
    a_sda_low_only: assert property (SDA_OUT == 1'b0)
        else $error("data line driven high");
    a_ack_scl_low: assert property ($rose(SDA_OE_OUT) |-> !SCL_IN)
        else $error("data pulled while clock high");
    a_release_scl_low: assert property ($fell(SDA_OE_OUT) |-> !SCL_IN)
        else $error("data released while clock high");
    a_phase_clamp: assert property (PHASE_STEP_OUT <= 4'hb)
        else $error("phase step above eleven");
    a_freeze_no_ce: assert property (!CE_IN |=> $stable({TRIGGER_OUT, BIAS_OUT, SDA_OE_OUT}))
        else $error("state moved while disabled");
endmodule

bind clock_trigger_recovery_regs crr_checker chk (
    .CLK_IN(CLK_IN), .RST_IN(RST_IN), .CE_IN(CE_IN), .ENC_LINE_IN(ENC_LINE_IN),
    .SCL_IN(SCL_IN), .SDA_IN(SDA_IN), .CHIP_ADDR_IN(CHIP_ADDR_IN), .SDA_OUT(SDA_OUT),
    .SDA_OE_OUT(SDA_OE_OUT), .REF_CLK_OUT(REF_CLK_OUT), .TRIGGER_OUT(TRIGGER_OUT),
    .PHASE_HALF_OUT(PHASE_HALF_OUT), .PHASE_STEP_OUT(PHASE_STEP_OUT), .BIAS_OUT(BIAS_OUT),
    .HIGH_GAIN_OUT(HIGH_GAIN_OUT), .GOING_OUT(GOING_OUT)
);

// ==== enc_line_model.sv ====
// source of the encoded clock and trigger line
module enc_line_model (
    // encoded line
    output logic line_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic pending = 1'b0;
    // returns once the accept cycle has begun on the line
    task automatic send_accept();
        pending = 1'b1;
        wait (pending == 1'b0);
    endtask
    // free running: a cycle opens high unless an accept keeps it low throughout
    initial
    begin
        line_out = 1'b0;
        forever
        begin
            line_out = ~pending;
            pending = 1'b0;
            #62.5;
            line_out = 1'b0;
            #62.5;
        end
    end
endmodule

// ==== tb_top.sv ====
// self-checking bench for the clock and trigger recovery block
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [4:0] STRAP = 5'h16;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        ce = 1'b1;
    logic        scl = 1'b1;
    logic        m_sda = 1'b1;
    logic [4:0]  straps = STRAP;
    wire         enc, sda_o, sda_oe, ref_clk, trig, half, gain, going;
    wire  [3:0]  step;
    wire  [15:0] bias;
    // pull-up: low whenever either side pulls
    wire         sda = m_sda & ~sda_oe;
    int          bad_count = 0;
    int          n_compared = 0;
    int          trig_count = 0;
    int          ref_rise = 0;
    logic        ref_d = 1'b0;

    // link period of 125 ns is 31.25 clocks
    clock_trigger_recovery_regs #(.CAL_DWELL(12'd4), .REF_CLKS(6'd31)) DUT (
        .CLK_IN(clk), .RST_IN(rst), .CE_IN(ce), .ENC_LINE_IN(enc), .SCL_IN(scl),
        .SDA_IN(sda), .CHIP_ADDR_IN(straps), .SDA_OUT(sda_o), .SDA_OE_OUT(sda_oe),
        .REF_CLK_OUT(ref_clk), .TRIGGER_OUT(trig), .PHASE_HALF_OUT(half),
        .PHASE_STEP_OUT(step), .BIAS_OUT(bias), .HIGH_GAIN_OUT(gain), .GOING_OUT(going)
    );
    enc_line_model link (.line_out(enc));

    initial
    begin
        forever #2 clk = ~clk;
    end
    always @(posedge clk)
    begin
        ref_d <= ref_clk;
        if (trig)
            trig_count++;
        if (ref_clk && !ref_d)
            ref_rise++;
    end

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(negedge clk);
    endtask
    // data only moves in the middle of the clock low phase
    task automatic put_bit(input logic b, output logic r);
        m_sda = b;
        wait_n(5);
        scl = 1'b1;
        wait_n(5);
        r = sda;
        wait_n(5);
        scl = 1'b0;
        wait_n(5);
    endtask
    task automatic put_byte(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--)
            put_bit(tx[i], rx[i]);
    endtask
    task automatic access(input logic [4:0] chip, input logic [1:0] sel, input logic rd,
                          input logic [7:0] wd, output logic ack, output logic [7:0] rdata);
        logic [7:0] junk;
        logic       a;
        m_sda = 1'b0;
        wait_n(10);
        scl = 1'b0;
        wait_n(5);
        put_byte({chip, sel, rd}, junk);
        put_bit(1'b1, a);
        put_byte(rd ? 8'hff : wd, rdata);
        put_bit(1'b1, junk[0]);
        m_sda = 1'b0;
        wait_n(5);
        scl = 1'b1;
        wait_n(5);
        m_sda = 1'b1;
        wait_n(10);
        ack = ~a;
    endtask
    task automatic wr(input logic [1:0] sel, input logic [7:0] d);
        logic       ack;
        logic [7:0] x;
        access(straps, sel, 1'b0, d, ack, x);
        check_val(16'(ack), 16'h0001);
    endtask
    task automatic rd_chk(input logic [1:0] sel, input logic [7:0] m, input logic [7:0] e);
        logic       ack;
        logic [7:0] x;
        access(straps, sel, 1'b1, 8'h00, ack, x);
        check_val(16'(ack), 16'h0001);
        check_val(16'(x & m), 16'(e));
    endtask
    // lag window in clocks from the accept cycle; 700 means nothing came
    task automatic measure(input int lo, input int hi, input int cnt);
        int t;
        int n;
        t = 0;
        n = trig_count;
        link.send_accept();
        while (trig !== 1'b1 && t < 700)
        begin
            @(negedge clk);
            t++;
        end
        check_val(16'(t >= lo && t < hi), 16'h0001);
        wait_n(40);
        check_val(16'(trig_count - n), 16'(cnt));
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        ce = 1'b0;
        wait_n(6);
        ce = 1'b1;
        rd_chk(2'h0, 8'hfc, 8'h00);
        rd_chk(2'h1, 8'hff, 8'h00);
        rd_chk(2'h2, 8'hff, 8'h00);
        rd_chk(2'h3, 8'hff, 8'h00);
        wr(2'h1, 8'h20);
        rd_chk(2'h3, 8'hff, 8'h00);
        $display("test reset done");
    endtask
    task automatic t_regs();
        wr(2'h1, 8'hdf);
        check_val(16'({half, step}), 16'h001b);
        wr(2'h2, 8'h5a);
        wr(2'h3, 8'ha5);
        wr(2'h0, 8'h80);
        check_val(bias, 16'ha55a);
        check_val(16'({gain, going}), 16'h0003);
        rd_chk(2'h0, 8'hff, 8'h83);
        wr(2'h1, 8'h23);
        check_val(16'({half, step, gain, going}), 16'h000c);
        wr(2'h3, 8'h0f);
        rd_chk(2'h3, 8'hff, 8'h0f);
        wr(2'h1, 8'h13);
        check_val(16'({half, step}), 16'h0013);
        rd_chk(2'h3, 8'hff, 8'ha5);
        rd_chk(2'h2, 8'hff, 8'h5a);
        wr(2'h0, 8'h00);
        $display("test regs done");
    endtask
    task automatic t_address();
        logic       ack;
        logic [7:0] x;
        access(STRAP ^ 5'h11, 2'h2, 1'b0, 8'h77, ack, x);
        check_val(16'(ack), 16'h0000);
        rd_chk(2'h2, 8'hff, 8'h5a);
        straps = 5'h09;
        wait_n(4);
        wr(2'h2, 8'h3c);
        rd_chk(2'h2, 8'hff, 8'h3c);
        straps = STRAP;
        wait_n(4);
        $display("test address done");
    endtask
    // a trigger is only known at the rise that ends the low cycle
    task automatic t_trig();
        int n;
        int r;
        int dl[3] = '{15, 1, 0};
        n = trig_count;
        r = ref_rise;
        wait_n(400);
        check_val(16'(trig_count - n), 16'h0000);
        check_val(16'(ref_rise - r >= 12 && ref_rise - r <= 13), 16'h0001);
        foreach (dl[i])
        begin
            wr(2'h1, 8'h20);
            wr(2'h3, 8'(dl[i]));
            wr(2'h1, 8'h00);
            measure(31 * dl[i] + 28, 32 * dl[i] + 40, 1);
        end
        // disabled output, then a test select code: neither may pass a trigger
        wr(2'h0, 8'h40);
        measure(700, 701, 0);
        wr(2'h0, 8'h30);
        measure(700, 701, 0);
        wr(2'h0, 8'h00);
        measure(28, 40, 1);
        $display("test trig done");
    endtask
    // one-zero write to the restart bit reruns calibration; a freeze mid-sweep
    task automatic t_restart();
        wr(2'h0, 8'h08);
        wr(2'h0, 8'h00);
        check_val(16'({gain, going}), 16'h0002);
        ce = 1'b0;
        wait_n(10);
        ce = 1'b1;
        wait_n(800);
        check_val(16'({gain, going}), 16'h0001);
        $display("test restart done");
    endtask

    task automatic print_verdict();
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial
    begin
        wait_n(3);
        check_val(16'({trig, sda_oe, going, half, step}), 16'h0000);
        check_val(bias, 16'h0000);
        rst = 1'b0;
        t_reset();
        t_regs();
        t_address();
        t_trig();
        t_restart();
        print_verdict();
    end
    // whole run needs about 70 us
    initial
    begin
        #400000;
        bad_count++;
        $display("watchdog expired");
        print_verdict();
    end
endmodule
